// ==== core/cie_top.v ====
// Purpose: Three-channel source-level interrupt enable registers with AXI4-Lite access
// Assumes: One write and one read in flight at most; conditions synchronous to aclk
// Notes: Unmapped addresses answer SLVERR, reads return zero there
`timescale 1ns/100ps
`include "cie_defines.vh"
module cie_top (
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite write address
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [7:0]  s_axi_awaddr,
   // AXI4-Lite write data
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   // AXI4-Lite write response
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   output reg  [1:0]  s_axi_bresp,
   // AXI4-Lite read address
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   input  wire [7:0]  s_axi_araddr,
   // AXI4-Lite read data
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   // Channel conditions, index 3 fifo, 2 unlock, 1 signal, 0 drive
   input  wire [3:0]  ch0_condition,
   input  wire [3:0]  ch1_condition,
   input  wire [3:0]  ch2_condition,
   // Interrupt change pulses per channel
   output wire [3:0]  ch0_change_irq,
   output wire [3:0]  ch1_change_irq,
   output wire [3:0]  ch2_change_irq
);
   // Stored enable bits; the upper four bits of each register are not kept
   reg  [3:0]  ch0_irq_source_enable;
   reg  [3:0]  ch1_irq_source_enable;
   reg  [3:0]  ch2_irq_source_enable;
   // Write channel state
   reg         aw_held;
   reg  [5:0]  aw_index;
   reg         w_held;
   reg  [7:0]  w_byte;
   reg         w_lane;
   wire        aw_take;
   wire        w_take;
   wire        do_write;
   wire        b_done;
   wire        write_hit;
   reg         write_ch0;
   reg         write_ch1;
   reg         write_ch2;
   wire [3:0]  next_enable;
   // Read channel state
   wire        ar_take;
   wire        r_done;
   wire [5:0]  ar_index;
   reg  [7:0]  read_byte;
   reg         read_hit;

   // Address and data are taken independently, each held until the response
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   // Completed handshakes
   assign aw_take       = s_axi_awvalid && s_axi_awready;
   assign w_take        = s_axi_wvalid && s_axi_wready;
   assign ar_take       = s_axi_arvalid && s_axi_arready;
   assign b_done        = s_axi_bvalid && s_axi_bready;
   assign r_done        = s_axi_rvalid && s_axi_rready;
   assign do_write      = aw_held && w_held && !s_axi_bvalid;
   assign ar_index      = s_axi_araddr[7:2];
   assign write_hit     = write_ch0 || write_ch1 || write_ch2;
   assign next_enable   = w_byte[3:0];

   // Write address is held until the write is carried out
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held  <= 1'b0;
         aw_index <= 6'h00;
      end else if (aw_take) begin
         aw_held  <= 1'b1;
         aw_index <= s_axi_awaddr[7:2];
      end else if (do_write) begin
         aw_held  <= 1'b0;
      end
   end

   // Only byte lane 0 carries register bits; with it off the write changes nothing
   always @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_byte <= 8'h00;
         w_lane <= 1'b0;
      end else if (w_take) begin
         w_held <= 1'b1;
         w_byte <= s_axi_wdata[7:0];
         w_lane <= s_axi_wstrb[0];
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   // Response follows the cycle in which both halves are held
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
      end else if (b_done) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bresp <= `CIE_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bresp <= write_hit ? `CIE_RESP_OKAY : `CIE_RESP_SLVERR;
      end
   end

   // Address decode for writes; an unmapped index answers SLVERR
   always @* begin
      write_ch0 = 1'b0;
      write_ch1 = 1'b0;
      write_ch2 = 1'b0;
      case (aw_index)
         `CIE_IDX_CH0: write_ch0 = 1'b1;
         `CIE_IDX_CH1: write_ch1 = 1'b1;
         `CIE_IDX_CH2: write_ch2 = 1'b1;
         default:      write_ch0 = 1'b0;
      endcase
   end

   // Channel 0 enable register
   always @(posedge aclk) begin
      if (!aresetn) begin
         ch0_irq_source_enable <= `CIE_EN_RESET;
      end else if (do_write && w_lane && write_ch0) begin
         ch0_irq_source_enable <= next_enable;
      end
   end

   // Channel 1 enable register
   always @(posedge aclk) begin
      if (!aresetn) begin
         ch1_irq_source_enable <= `CIE_EN_RESET;
      end else if (do_write && w_lane && write_ch1) begin
         ch1_irq_source_enable <= next_enable;
      end
   end

   // Channel 2 enable register
   always @(posedge aclk) begin
      if (!aresetn) begin
         ch2_irq_source_enable <= `CIE_EN_RESET;
      end else if (do_write && w_lane && write_ch2) begin
         ch2_irq_source_enable <= next_enable;
      end
   end

   // Read decode; unmapped reads give zero data
   always @* begin
      read_hit  = 1'b1;
      read_byte = 8'h00;
      case (ar_index)
         `CIE_IDX_CH0: read_byte = {4'h0, ch0_irq_source_enable};
         `CIE_IDX_CH1: read_byte = {4'h0, ch1_irq_source_enable};
         `CIE_IDX_CH2: read_byte = {4'h0, ch2_irq_source_enable};
         default:      read_hit  = 1'b0;
      endcase
   end

   // Read data stands until rready
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
      end else if (ar_take) begin
         s_axi_rvalid <= 1'b1;
      end else if (r_done) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Data and code load only when an address is taken, so they stand with rvalid
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `CIE_RESP_OKAY;
      end else if (ar_take) begin
         s_axi_rdata <= {24'h00_0000, read_byte};
         s_axi_rresp <= read_hit ? `CIE_RESP_OKAY : `CIE_RESP_SLVERR;
      end
   end

   // Each channel is gated only by its own register
   cie_channel u_ch0 (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .enable     (ch0_irq_source_enable),
      .condition  (ch0_condition),
      .change_irq (ch0_change_irq)
   );

   cie_channel u_ch1 (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .enable     (ch1_irq_source_enable),
      .condition  (ch1_condition),
      .change_irq (ch1_change_irq)
   );

   cie_channel u_ch2 (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .enable     (ch2_irq_source_enable),
      .condition  (ch2_condition),
      .change_irq (ch2_change_irq)
   );
endmodule

// ==== core/cie_defines.vh ====
// Purpose: Constants for the per-channel interrupt source enable block
// Assumes: AXI4-Lite with 32-bit data, byte addresses are four times the register index
// Notes: Offsets are register indices, the bus byte address is four times the index
// Summary of operation
// - Enable bit 3 lets each assertion or removal of the channel's FIFO-limit alarm raise an interrupt.
// - Enable bit 2 lets each assertion or removal of the channel's receive loss-of-lock raise an interrupt.
// - Enable bit 1 lets each assertion or removal of the channel's loss-of-signal defect raise an interrupt.
// - Enable bit 0 lets each rise or fall of the channel's drive-monitor output raise an interrupt.
// - An enable bit at zero suppresses its interrupt and at one permits it.
// - The four enable bits are writable by the host and read back the value last written.
// - Each channel has its own enable register at index 0x01, 0x09 and 0x11, gating only that channel.
`ifndef CIE_DEFINES_VH
`define CIE_DEFINES_VH

`define CIE_IDX_CH0       6'h01
`define CIE_IDX_CH1       6'h09
`define CIE_IDX_CH2       6'h11
`define CIE_ADDR_W        8
`define CIE_EN_RESET      4'h0
`define CIE_BIT_FIFO      3
`define CIE_BIT_UNLOCK    2
`define CIE_BIT_SIGNAL    1
`define CIE_BIT_DRIVE     0
`define CIE_RESP_OKAY     2'b00
`define CIE_RESP_SLVERR   2'b10

`endif

// ==== core/cie_channel.v ====
// Purpose: One channel of change-of-condition detection gated by its enable bits
// Assumes: Condition inputs are synchronous to aclk
// Notes: Pulses one cycle after each change of an enabled condition
`timescale 1ns/100ps
module cie_channel (
   // Clock and reset
   input  wire       aclk,
   input  wire       aresetn,
   // Enables and conditions, bit order fifo, unlock, signal, drive
   input  wire [3:0] enable,
   input  wire [3:0] condition,
   // Per-source change pulses
   output reg  [3:0] change_irq
);
   reg [3:0] last_condition;

   always @(posedge aclk) begin
      if (!aresetn) begin
         last_condition <= 4'h0;
         change_irq     <= 4'h0;
      end else begin
         last_condition <= condition;
         // Either edge counts; a zero enable masks it
         change_irq     <= (condition ^ last_condition) & enable;
      end
   end
endmodule

// ==== sim/cie_cond_model.sv ====
// Purpose: Condition source for all three channels
// Assumes: Driven by the bench on aclk
// Notes: Toggles each condition whose flip bit is set
`timescale 1ns/100ps
module cie_cond_model (
   // Clock
   input  wire         aclk,
   // Toggle request, ch2 in 11:8, ch0 in 3:0
   input  wire  [11:0] flip,
   // Condition levels
   output logic [11:0] cond
);
   initial cond = 12'h000;
   always @(posedge aclk) cond <= cond ^ flip;
endmodule

// ==== sim/cie_chk_assertions.sv ====
// Purpose: Bus and change pulse checks
// Assumes: Sees the top ports only
// Notes: Enables are internal, so pulses are tied to condition changes
`timescale 1ns/100ps
module cie_chk (
   input wire        aclk, aresetn, s_axi_bvalid, s_axi_awready, s_axi_rvalid,
   input wire [1:0]  s_axi_bresp,
   input wire [31:0] s_axi_rdata,
   input wire [3:0]  ch0_condition, ch1_condition, ch2_condition, ch0_change_irq, ch1_change_irq, ch2_change_irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   fifo_cause_a: assert property (ch1_change_irq[3] |-> $past(ch1_condition[3], 2) != $past(ch1_condition[3]))
      else $error("fifo pulse without change");
   unlock_cause_a: assert property (ch0_change_irq[2] |-> $past(ch0_condition[2], 2) != $past(ch0_condition[2]))
      else $error("unlock pulse without change");
   unlock_width_a: assert property (ch0_change_irq[2] && $stable(ch0_condition[2]) |=> !ch0_change_irq[2])
      else $error("unlock pulse too long");
   signal_cause_a: assert property (ch1_change_irq[1] |-> $past(ch1_condition[1], 2) != $past(ch1_condition[1]))
      else $error("signal pulse without change");
   drive_cause_a: assert property (ch2_change_irq[0] |-> $past(ch2_condition[0], 2) != $past(ch2_condition[0]))
      else $error("drive pulse without change");
   write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("address taken during response");
   upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0)
      else $error("upper bits not zero");
   reset_clear_a: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && ch0_change_irq == 4'h0)
      else $error("reset did not clear");
   cover property (ch1_change_irq[3]);
   cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
   cover property (ch2_change_irq[0]);
endmodule
bind cie_top cie_chk chk_u (.aclk, .aresetn, .s_axi_bvalid, .s_axi_awready, .s_axi_rvalid, .s_axi_bresp, .s_axi_rdata,
   .ch0_condition, .ch1_condition, .ch2_condition, .ch0_change_irq, .ch1_change_irq, .ch2_change_irq);

// ==== sim/tb.sv ====
// Purpose: Register and change pulse bench
// Assumes: Write and read never overlap
// Notes: Rows cover mapped, unmapped and strobe-off writes
`timescale 1ns/100ps
`include "cie_defines.vh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin mismatches++; $display("wrong value %0t got %h want %h", $time, a, e); end end
module tb;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        bvalid, rvalid, awready, wready, arready;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic [3:0]  wstrb = 0;
   logic [31:0] wdata = 0, rdata, q;
   logic [1:0]  bresp, rresp, r;
   logic [11:0] flip = 0, cond;
   wire  [11:0] irq;
   int          mismatches = 0, n_compared = 0;
   logic [7:0]  ta [5] = '{8'h04, 8'h24, 8'h44, 8'h0c, 8'h04};
   logic [7:0]  td [5] = '{8'hff, 8'h05, 8'h0a, 8'h03, 8'h03};
   logic [3:0]  ts [5] = '{4'hf, 4'hf, 4'hf, 4'hf, 4'h0};
   logic [31:0] tq [5] = '{32'h0f, 32'h05, 32'h0a, 32'h00, 32'h0f};
   logic [1:0]  tr [5] = '{`CIE_RESP_OKAY, `CIE_RESP_OKAY, `CIE_RESP_OKAY, `CIE_RESP_SLVERR, `CIE_RESP_OKAY};
   cie_cond_model far_u (.aclk(aclk), .flip(flip), .cond(cond));
   cie_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .ch0_condition(cond[3:0]), .ch1_condition(cond[7:4]),
      .ch2_condition(cond[11:8]), .ch0_change_irq(irq[3:0]), .ch1_change_irq(irq[7:4]), .ch2_change_irq(irq[11:8]));
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
      awaddr <= a;
      wdata <= {24'h0, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      q = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   // One toggle, then the pulse must last exactly one cycle
   task automatic pulse(input logic [11:0] f, input logic [11:0] e);
      flip <= f;
      @(posedge aclk);
      flip <= 12'h000;
      @(posedge aclk);
      #1 `CHK(irq, e)
      @(posedge aclk);
      #1 `CHK(irq, 12'h000)
   endtask
   task automatic tally_and_finish();
      if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial forever #5 aclk = ~aclk;
   initial begin
      #100us;
      mismatches++;
      tally_and_finish();
   end
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      foreach (ta[i]) begin
         wr(ta[i], td[i], ts[i]);
         `CHK(r, tr[i])
         rd(ta[i]);
         `CHK(q, tq[i])
         `CHK(r, tr[i])
      end
      wr(8'h04, 8'h05, 4'hf);
      wr(8'h24, 8'h0a, 4'hf);
      wr(8'h44, 8'h09, 4'hf);
      pulse(12'hfff, 12'h9a5);
      pulse(12'hfff, 12'h9a5);
      pulse(12'h008, 12'h000);
      @(posedge aclk);
      aresetn <= 1'b0;
      @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(8'h24);
      `CHK(q, 32'h0)
      tally_and_finish();
   end
endmodule
